// file: isp_core.sv
// Notes on behaviour
// R1: address and data bytes shift most significant bit first.
// R2: direction bit one means host reads, zero means host writes.
// R3: addressed client acknowledges by pulling data low; the code refuses a matching address while the buffer is full.
// R4: data changes only while clock is low; high-clock changes are start/stop.
// R5: on writes the client acknowledges every received byte; the code refuses it while the buffer is full or C2_NACK is set.
// R6: on reads the host acknowledges every byte the client sends.
// R7: stop is data rising with clock high; ends the transfer.
// R8: restart instead of stop begins a new transfer without freeing the bus.
// R9: single write, single read, or combined messages are all handled.
// R10: status low six bits read-only, top two bits read/write.
// R11: the three control registers are fully read/write.
// R12: the mask gates which address bits take part in matching.
// R13: address register is own address; in host mode it reloads the rate counter.
// R14: a full received byte moves to the buffer and sets the flag; the code drops the byte while the buffer is full.
// R15: writing the buffer loads buffer and shift register together.
// R16: bus idle with no host and both lines high; active otherwise.
// R17: an address matches only when equal to the own address; the code compares only bits 7:1 under the mask.
// R18: after a read request the client supplies bytes until restart or stop.
// R19: data sampled low while released-and-expected-high flags a collision.
// R20: any party may hold clock low; others wait for its release.
// R21: start is data falling with clock high, then the address byte.
// R22: nine clocks per unit; transmitter releases data after eighth fall.
// R23: disabled or reset: bit counter zero, both lines released.
`timescale 1ns/1ns
module isp_core (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// register port
	input  wire logic [isp_pkg::AW-1:0]   addr,
	input  wire logic [isp_pkg::DW-1:0]   wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic      [isp_pkg::DW-1:0]   rdata,
	// serial clock line
	input  wire logic                     scl_in,
	output logic                          scl_out,
	output logic                          scl_oe_n,
	// serial data line
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe_n,
	// host mode rate tick
	output logic                          rate_tick
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		isp_pkg::isp_state_e      st;
		logic [isp_pkg::CW-1:0]   bitcnt;
		logic [isp_pkg::DW-1:0]   shift;
		logic [isp_pkg::DW-1:0]   data_buf;
		logic [1:0]               status_rw;
		logic                     full;
		logic                     rw;
		logic                     start_seen;
		logic                     stop_seen;
		logic                     data_seen;
		logic                     active;
		logic                     host_ack;
		logic [isp_pkg::DW-1:0]   ctrl1;
		logic [isp_pkg::DW-1:0]   ctrl2;
		logic [isp_pkg::DW-1:0]   ctrl3;
		logic [isp_pkg::DW-1:0]   own_addr;
		logic [isp_pkg::DW-1:0]   mask;
		logic                     iflag;
		logic                     scl_p;
		logic                     sda_p;
		logic                     sda_oe_n;
		logic                     scl_oe_n;
		logic [isp_pkg::DW-1:0]   rdata;
		logic [isp_pkg::DW-1:0]   rate_cnt;
		logic                     rate_tick;
		logic                     out_lo;
	} isp_core_s;

	localparam isp_core_s S_RST = '{
		st:       isp_pkg::ST_IDLE,
		ctrl1:    isp_pkg::RST_CTRL1,
		mask:     isp_pkg::RST_MASK,
		scl_p:    1'b1,
		sda_p:    1'b1,
		sda_oe_n: 1'b1,
		scl_oe_n: 1'b1,
		default:  '0
	};

	isp_core_s s;
	isp_core_s next_s;
	logic      rst_a;
	logic      rst_n;
	logic      scl_f;
	logic      sda_f;
	logic      start_det;
	logic      stop_det;
	logic      rise;
	logic      fall;
	logic      en;

	// ************************************************************
	// reset release and pin filters
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end

	isp_sync #(.INIT(1'b1)) u_scl_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (scl_in),
		.q     (scl_f)
	);

	isp_sync #(.INIT(1'b1)) u_sda_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (sda_in),
		.q     (sda_f)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	// masked compare of bits 7:1; an all-ones mask gives equality of those seven bits
	function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] own,
			input logic [7:0] msk);
		addr_match = ((rx[7:1] & msk[7:1]) == (own[7:1] & msk[7:1]));
	endfunction : addr_match

	function automatic logic [7:0] reg_read(input isp_core_s r, input logic [2:0] a);
		case (a)
			isp_pkg::OFF_STATUS: reg_read = {r.status_rw, r.active, r.data_seen,
					r.stop_seen, r.start_seen, r.rw, r.full};
			isp_pkg::OFF_CTRL1:  reg_read = r.ctrl1;
			isp_pkg::OFF_CTRL2:  reg_read = r.ctrl2;
			isp_pkg::OFF_CTRL3:  reg_read = r.ctrl3;
			isp_pkg::OFF_BUF:    reg_read = r.data_buf;
			isp_pkg::OFF_ADDR:   reg_read = r.own_addr;
			isp_pkg::OFF_MASK:   reg_read = r.mask;
			isp_pkg::OFF_FLAG:   reg_read = {7'h00, r.iflag};
			default:             reg_read = isp_pkg::RST_ZERO;
		endcase
	endfunction : reg_read

	// line events from the filtered levels; r4 makes high-clock data moves conditions
	assign start_det = scl_f && s.scl_p && s.sda_p && !sda_f; // [R21] [R4]
	assign stop_det  = scl_f && s.scl_p && !s.sda_p && sda_f; // [R7] [R4]
	assign rise      = scl_f && !s.scl_p;
	assign fall      = !scl_f && s.scl_p;
	assign en        = s.ctrl1[isp_pkg::C1_EN];

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_s           = s;
		next_s.rdata     = isp_pkg::RST_ZERO;
		next_s.rate_tick = 1'b0;
		next_s.out_lo    = 1'b0;
		next_s.scl_p     = scl_f;
		next_s.sda_p     = sda_f;

		// software side first so that hardware sets below win
		if (wr) begin
			case (addr)
				isp_pkg::OFF_STATUS: next_s.status_rw = wdata[7:isp_pkg::SB_RW_LO]; // [R10]
				isp_pkg::OFF_CTRL1:  next_s.ctrl1 = wdata; // [R11]
				isp_pkg::OFF_CTRL2:  next_s.ctrl2 = wdata; // [R11]
				isp_pkg::OFF_CTRL3:  next_s.ctrl3 = wdata; // [R11]
				isp_pkg::OFF_ADDR:   next_s.own_addr = wdata;
				isp_pkg::OFF_MASK:   next_s.mask = wdata;
				isp_pkg::OFF_FLAG:   next_s.iflag = wdata[isp_pkg::FLAG_BIT];
				isp_pkg::OFF_BUF: begin
					next_s.data_buf = wdata; // [R15]
					next_s.shift    = wdata; // [R15]
					if (s.st == isp_pkg::ST_TX_WAIT) begin
						next_s.st       = isp_pkg::ST_TX;
						next_s.bitcnt   = '0;
						next_s.sda_oe_n = wdata[7]; // [R1]
						next_s.scl_oe_n = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (rd) begin
			next_s.rdata = reg_read(s, addr);
			if (addr == isp_pkg::OFF_BUF) begin
				next_s.full = 1'b0;
			end
		end

		// host mode reuses the address register as rate reload
		if (s.ctrl1[isp_pkg::C1_HOST]) begin
			if (s.rate_cnt == isp_pkg::RST_ZERO) begin
				next_s.rate_cnt  = s.own_addr; // [R13]
				next_s.rate_tick = 1'b1;
			end else begin
				next_s.rate_cnt = s.rate_cnt - 8'h01;
			end
		end else begin
			next_s.rate_cnt = s.own_addr;
		end

		// client engine
		if (!en || s.ctrl1[isp_pkg::C1_HOST]) begin
			next_s.st       = isp_pkg::ST_IDLE; // [R23]
			next_s.bitcnt   = '0; // [R23]
			next_s.sda_oe_n = 1'b1; // [R23]
			next_s.scl_oe_n = 1'b1; // [R23]
			next_s.active   = 1'b0;
		end else if (start_det) begin
			// a restart lands here too and restarts the address phase from bit zero
			next_s.st         = isp_pkg::ST_ADDR; // [R21] [R8]
			next_s.bitcnt     = '0;
			next_s.active     = 1'b1; // [R16]
			next_s.start_seen = 1'b1;
			next_s.stop_seen  = 1'b0;
			next_s.sda_oe_n   = 1'b1;
			next_s.scl_oe_n   = 1'b1;
		end else if (stop_det) begin
			next_s.st         = isp_pkg::ST_IDLE; // [R7]
			next_s.active     = 1'b0; // [R16]
			next_s.stop_seen  = 1'b1;
			next_s.start_seen = 1'b0;
			next_s.sda_oe_n   = 1'b1;
			next_s.scl_oe_n   = 1'b1;
		end else begin
			case (s.st)
				isp_pkg::ST_IDLE: ;
				isp_pkg::ST_ADDR, isp_pkg::ST_RX: begin
					if (rise && s.bitcnt < isp_pkg::BIT_BYTE) begin
						next_s.shift  = {s.shift[6:0], sda_f}; // [R1]
						next_s.bitcnt = s.bitcnt + 4'h1;
					end
					if (fall && s.bitcnt == isp_pkg::BIT_BYTE) begin
						if (s.st == isp_pkg::ST_ADDR) begin
							if (addr_match(s.shift, s.own_addr, s.mask) && !s.full) begin // [R17] [R12]
								next_s.st        = isp_pkg::ST_ADDR_ACK;
								next_s.sda_oe_n  = 1'b0; // [R3]
								next_s.rw        = s.shift[0]; // [R2]
								next_s.data_seen = 1'b0;
								next_s.data_buf  = s.shift; // [R14]
								next_s.full      = 1'b1;
								next_s.iflag     = 1'b1;
							end else begin
								// not for us, or buffer full: sit out until the next condition
								next_s.st = isp_pkg::ST_IDLE;
							end
						end else begin
							next_s.st        = isp_pkg::ST_RX_ACK;
							next_s.data_seen = 1'b1;
							if (s.full) begin
								// unread buffer: keep it, refuse the byte
								next_s.ctrl1[isp_pkg::C1_OVF] = 1'b1;
							end else begin
								next_s.data_buf = s.shift; // [R14]
								next_s.full     = 1'b1;
								next_s.iflag    = 1'b1; // [R14]
								next_s.sda_oe_n = s.ctrl2[isp_pkg::C2_NACK]; // [R5] [R3]
							end
						end
					end
				end
				isp_pkg::ST_ADDR_ACK, isp_pkg::ST_RX_ACK: begin
					if (rise) begin
						next_s.bitcnt = isp_pkg::BIT_ACK; // [R22]
					end
					if (fall && s.bitcnt == isp_pkg::BIT_ACK) begin
						next_s.bitcnt   = '0;
						next_s.sda_oe_n = 1'b1;
						if (s.st == isp_pkg::ST_ADDR_ACK && s.rw) begin
							// hold the clock until software supplies a byte
							next_s.st       = isp_pkg::ST_TX_WAIT; // [R20] [R18]
							next_s.scl_oe_n = 1'b0;
						end else begin
							next_s.st = isp_pkg::ST_RX; // [R5] [R9]
						end
					end
				end
				isp_pkg::ST_TX_WAIT: begin
					// a buffer write this cycle has already let go of the clock
					if (next_s.st == isp_pkg::ST_TX_WAIT) begin
						next_s.scl_oe_n = 1'b0; // [R20]
					end
				end
				isp_pkg::ST_TX: begin
					if (rise && s.bitcnt < isp_pkg::BIT_BYTE) begin
						if (s.shift[7] && !sda_f) begin
							next_s.ctrl1[isp_pkg::C1_COLL] = 1'b1; // [R19]
							next_s.st       = isp_pkg::ST_IDLE;
							next_s.sda_oe_n = 1'b1;
						end else begin
							next_s.shift  = {s.shift[6:0], 1'b0}; // [R1]
							next_s.bitcnt = s.bitcnt + 4'h1;
						end
					end
					if (fall && s.bitcnt == isp_pkg::BIT_BYTE) begin
						next_s.st       = isp_pkg::ST_TX_ACK;
						next_s.sda_oe_n = 1'b1; // [R22]
					end else if (fall && s.bitcnt != '0) begin
						next_s.sda_oe_n = s.shift[7]; // [R4] [R1]
					end
				end
				isp_pkg::ST_TX_ACK: begin
					if (rise) begin
						next_s.bitcnt   = isp_pkg::BIT_ACK; // [R22]
						next_s.host_ack = !sda_f; // [R6]
					end
					if (fall && s.bitcnt == isp_pkg::BIT_ACK) begin
						next_s.bitcnt = '0;
						if (s.host_ack) begin
							next_s.st       = isp_pkg::ST_TX_WAIT; // [R18]
							next_s.scl_oe_n = 1'b0;
							next_s.iflag    = 1'b1;
						end else begin
							next_s.st = isp_pkg::ST_IDLE; // [R7]
						end
					end
				end
				default: next_s.st = isp_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= S_RST;
		end else begin
			s <= next_s;
		end
	end

	assign rdata     = s.rdata;
	assign scl_out   = s.out_lo;
	assign sda_out   = s.out_lo;
	assign scl_oe_n  = s.scl_oe_n;
	assign sda_oe_n  = s.sda_oe_n;
	assign rate_tick = s.rate_tick;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_start_to_addr: assert property (en && !s.ctrl1[isp_pkg::C1_HOST] && start_det |=> // [R21]
			s.st == isp_pkg::ST_ADDR && s.bitcnt == '0 && s.active)
		else $error("start did not open address phase");
	a_stop_to_idle: assert property (en && !s.ctrl1[isp_pkg::C1_HOST] && !start_det && // [R7]
			stop_det |=> s.st == isp_pkg::ST_IDLE && !s.active && s.sda_oe_n)
		else $error("stop did not free the bus");
	a_ack_drive: assert property (s.st == isp_pkg::ST_ADDR_ACK |-> !s.sda_oe_n) // [R3]
		else $error("address ack not driven low");
	a_dir_bit: assert property (s.st == isp_pkg::ST_ADDR_ACK |-> s.rw == s.data_buf[0]) // [R2]
		else $error("direction bit not captured");
	a_sda_clock_low: assert property ($changed(s.sda_oe_n) && $past(s.st) != isp_pkg::ST_IDLE && // [R4]
			s.st != isp_pkg::ST_IDLE && s.st != isp_pkg::ST_ADDR |-> !$past(scl_f))
		else $error("data moved while clock high");
	a_rx_to_buffer: assert property ($rose(s.full) |-> s.iflag && s.data_buf == $past(s.shift)) // [R14]
		else $error("received byte not moved to buffer");
	a_tx_load_both: assert property (wr && addr == isp_pkg::OFF_BUF |=> // [R15]
			s.data_buf == $past(wdata) && s.shift == $past(wdata))
		else $error("buffer write did not load shift register");
	a_ack_release: assert property (s.st == isp_pkg::ST_TX_ACK |-> s.sda_oe_n) // [R22]
		else $error("transmitter kept data during ack");
	a_collision_flag: assert property (en && !start_det && !stop_det && s.st == isp_pkg::ST_TX && // [R19]
			rise && s.bitcnt < isp_pkg::BIT_BYTE && s.shift[7] && !sda_f |=>
			s.ctrl1[isp_pkg::C1_COLL] && s.st == isp_pkg::ST_IDLE)
		else $error("collision not flagged");
	a_disable_rel: assert property (!en |=> s.st == isp_pkg::ST_IDLE && s.bitcnt == '0 && // [R23]
			s.sda_oe_n && s.scl_oe_n)
		else $error("disabled engine not released");
	a_stretch_hold: assert property (s.st == isp_pkg::ST_TX_WAIT && $past(s.st) == // [R20]
			isp_pkg::ST_TX_WAIT |-> !s.scl_oe_n)
		else $error("clock not held while waiting for data");

endmodule : isp_core

// file: isp_core_tb_top.sv
`timescale 1ns/1ns
module isp_core_tb_top;
	// ************************************************************
	// signals
	// ************************************************************
	localparam logic [6:0] ADR      = 7'h2A;
	localparam logic [7:0] EN_BIT   = 8'h01 << isp_pkg::C1_EN;
	localparam logic [7:0] HOST_BIT = 8'h01 << isp_pkg::C1_HOST;
	localparam logic [7:0] OVF_BIT  = 8'h01 << isp_pkg::C1_OVF;
	localparam logic [7:0] COLL_BIT = 8'h01 << isp_pkg::C1_COLL;
	logic                   clk, rstn, wr, rd, rd_q, rate_tick;
	logic [isp_pkg::AW-1:0] addr;
	logic [isp_pkg::DW-1:0] wdata, rdata, v, w, got;
	logic                   scl_out, scl_oe_n, sda_out, sda_oe_n, h_scl_oe_n, h_sda_oe_n;
	wire                    scl_line, sda_line;
	logic [isp_pkg::DW-1:0] exp_q[$];
	int                     num_errors, total_checks, n;

	// pulled-up wires: any low pull wins
	assign scl_line = h_scl_oe_n & (scl_oe_n | scl_out);
	assign sda_line = h_sda_oe_n & (sda_oe_n | sda_out);

	isp_core dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .rate_tick(rate_tick));

	isp_host_model host (.scl(scl_line), .sda(sda_line), .scl_oe_n(h_scl_oe_n),
		.sda_oe_n(h_sda_oe_n));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ************************************************************
	// compare and bus tasks
	// ************************************************************
	task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk8

	task automatic chk1(input string what, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", what, e, g);
		end
	endtask : chk1

	// strobe is lowered on its own edge, so a new call waits one more edge
	task automatic reg_wr(input logic [isp_pkg::AW-1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [isp_pkg::AW-1:0] a, input logic [7:0] e);
		@(posedge clk);
		exp_q.push_back(e);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask : reg_rd

	task automatic send(input logic [7:0] d, input logic e);
		logic a;
		host.write_byte(d, a);
		chk1("ack", e, a);
	endtask : send

	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_q <= rd;
		if (rd_q === 1'b1 && exp_q.size() > 0) chk8("rdata", exp_q.pop_front(), rdata);
	end

	task automatic stop_test();
		num_errors += host.timeouts + exp_q.size();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	initial begin
		#500000;
		num_errors++;
		stop_test();
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		void'($urandom(92));
		num_errors = 0;
		total_checks = 0;
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		rd_q = 1'b0;
		addr = '0;
		wdata = '0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			v = (i == 6) ? isp_pkg::RST_MASK : isp_pkg::RST_ZERO;
			reg_rd(i[2:0], v);
		end
		for (int i = 1; i < 4; i++) begin
			v = 8'($urandom);
			reg_wr(i[2:0], v);
			reg_rd(i[2:0], v);
		end
		reg_wr(isp_pkg::OFF_CTRL1, 8'h00);
		reg_wr(isp_pkg::OFF_CTRL2, 8'h00);
		reg_wr(isp_pkg::OFF_STATUS, 8'hFF);
		reg_rd(isp_pkg::OFF_STATUS, 8'hC0);
		reg_wr(isp_pkg::OFF_STATUS, 8'h00);
		$display("done: register access");
		reg_wr(isp_pkg::OFF_ADDR, 8'h03);
		reg_rd(isp_pkg::OFF_ADDR, 8'h03);
		reg_wr(isp_pkg::OFF_CTRL1, HOST_BIT);
		for (n = 0; n < 50 && rate_tick !== 1'b1; n++) @(posedge clk);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rate_tick !== 1'b1 && n < 50);
		chk8("tick gap", 8'h04, n[7:0]);
		reg_wr(isp_pkg::OFF_CTRL1, 8'h00);
		$display("done: rate reload");
		reg_wr(isp_pkg::OFF_ADDR, {ADR, 1'b0});
		reg_wr(isp_pkg::OFF_CTRL1, EN_BIT);
		repeat (8) @(posedge clk);
		for (int i = 0; i < 3; i++) begin
			reg_wr(isp_pkg::OFF_MASK, (i == 2) ? 8'hFD : 8'hFF);
			v = {((i == 0) ? ADR : ADR ^ 7'h01), 1'b0};
			host.start();
			send(v, 1'(i == 1));
			if (i != 1) reg_rd(isp_pkg::OFF_FLAG, 8'h01);
			if (i != 1) reg_rd(isp_pkg::OFF_BUF, v);
			reg_wr(isp_pkg::OFF_FLAG, 8'h00);
			host.stop();
		end
		reg_wr(isp_pkg::OFF_MASK, 8'hFF);
		$display("done: address match");
		host.start();
		send({ADR, 1'b0}, 1'b0);
		reg_rd(isp_pkg::OFF_BUF, {ADR, 1'b0});
		v = 8'($urandom);
		w = 8'($urandom);
		send(v, 1'b0);
		send(w, 1'b1);
		reg_rd(isp_pkg::OFF_CTRL1, EN_BIT | OVF_BIT);
		reg_rd(isp_pkg::OFF_BUF, v);
		reg_wr(isp_pkg::OFF_CTRL1, EN_BIT);
		reg_wr(isp_pkg::OFF_FLAG, 8'h00);
		host.start();
		send({ADR, 1'b1}, 1'b0);
		reg_rd(isp_pkg::OFF_BUF, {ADR, 1'b1});
		for (int i = 0; i < 2; i++) begin
			repeat (8) @(posedge clk);
			chk1("scl hold", 1'b0, scl_oe_n);
			v = 8'($urandom);
			reg_wr(isp_pkg::OFF_BUF, v);
			host.read_byte(i[0], got);
			chk8("rx byte", v, got);
		end
		host.stop();
		$display("done: combined message");
		host.start();
		send({ADR, 1'b1}, 1'b0);
		reg_rd(isp_pkg::OFF_BUF, {ADR, 1'b1});
		repeat (8) @(posedge clk);
		reg_wr(isp_pkg::OFF_BUF, 8'hFF);
		send(8'h00, 1'b1);
		reg_rd(isp_pkg::OFF_CTRL1, EN_BIT | COLL_BIT);
		reg_wr(isp_pkg::OFF_CTRL1, EN_BIT);
		host.stop();
		$display("done: collision");
		host.start();
		send({ADR, 1'b1}, 1'b0);
		repeat (8) @(posedge clk);
		reg_wr(isp_pkg::OFF_CTRL1, 8'h00);
		repeat (2) @(posedge clk);
		chk1("scl release", 1'b1, scl_oe_n);
		chk1("sda release", 1'b1, sda_oe_n);
		host.stop();
		$display("done: disable release");
		repeat (4) @(posedge clk);
		stop_test();
	end
endmodule : isp_core_tb_top

// file: isp_host_model.sv
`timescale 1ns/1ns
module isp_host_model (
	// resolved bus lines
	input  wire logic scl,
	input  wire logic sda,
	// pulls, low drives the line
	output logic      scl_oe_n,
	output logic      sda_oe_n
);
	int timeouts;

	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
		timeouts = 0;
	end

	// ************************************************************
	// one clock pulse, 80 ns
	// ************************************************************
	// sampling late in the high phase keeps clear of the client's filter delay
	// odd offsets keep every line move off the bench clock edges
	task automatic pulse(input logic b, output logic s);
		int n;
		n = 0;
		#11 sda_oe_n = b;
		#30 scl_oe_n = 1'b1;
		while (scl !== 1'b1 && n < 5000) begin
			#8 n++;
		end
		if (n >= 5000) timeouts++;
		#35 s = sda;
		#3 scl_oe_n = 1'b0;
		#1;
	endtask : pulse

	// ************************************************************
	// framing
	// ************************************************************
	task automatic start();
		#11 sda_oe_n = 1'b1;
		#30 scl_oe_n = 1'b1;
		#40 sda_oe_n = 1'b0;
		#38 scl_oe_n = 1'b0;
		#1;
	endtask : start

	task automatic stop();
		#11 sda_oe_n = 1'b0;
		#30 scl_oe_n = 1'b1;
		#40 sda_oe_n = 1'b1;
		#39;
	endtask : stop

	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(d[i], s);
		pulse(1'b1, ack);
	endtask : write_byte

	task automatic read_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b1, s);
			d[i] = s;
		end
		pulse(nack, s);
	endtask : read_byte
endmodule : isp_host_model

// file: isp_pkg.sv
package isp_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int AW = 3;
	localparam int DW = 8;
	localparam int CW = 4;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [AW-1:0] OFF_STATUS = 3'h0;
	localparam logic [AW-1:0] OFF_CTRL1  = 3'h1;
	localparam logic [AW-1:0] OFF_CTRL2  = 3'h2;
	localparam logic [AW-1:0] OFF_CTRL3  = 3'h3;
	localparam logic [AW-1:0] OFF_BUF    = 3'h4;
	localparam logic [AW-1:0] OFF_ADDR   = 3'h5;
	localparam logic [AW-1:0] OFF_MASK   = 3'h6;
	localparam logic [AW-1:0] OFF_FLAG   = 3'h7;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int SB_RW_LO  = 6;
	localparam int C1_COLL   = 7;
	localparam int C1_OVF    = 6;
	localparam int C1_EN     = 5;
	localparam int C1_HOST   = 3;
	localparam int C2_NACK   = 5;
	localparam int FLAG_BIT  = 0;

	// ************************************************************
	// reset values and counts
	// ************************************************************
	localparam logic [DW-1:0] RST_ZERO  = 8'h00;
	localparam logic [DW-1:0] RST_MASK  = 8'hFF;
	localparam logic [DW-1:0] RST_CTRL1 = 8'h00;
	localparam logic [CW-1:0] BIT_BYTE  = 4'h8;
	localparam logic [CW-1:0] BIT_ACK   = 4'h9;

	// ************************************************************
	// client engine states
	// ************************************************************
	typedef enum logic [7:0] {
		ST_IDLE    = 8'h01,
		ST_ADDR    = 8'h02,
		ST_ADDR_ACK = 8'h04,
		ST_RX      = 8'h08,
		ST_RX_ACK  = 8'h10,
		ST_TX_WAIT = 8'h20,
		ST_TX      = 8'h40,
		ST_TX_ACK  = 8'h80
	} isp_state_e;

endpackage : isp_pkg

// file: isp_sync.sv
`timescale 1ns/1ns
module isp_sync #(
	parameter logic INIT = 1'b1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pin in, filtered level out
	input  wire logic din,
	output logic      q
);

	typedef struct packed {
		logic q1;
		logic q2;
		logic q3;
		logic q;
	} isp_sync_s;

	isp_sync_s s;
	isp_sync_s next_s;

	// q1 feeds only q2; a change counts once q2 and q3 agree
	always_comb begin
		next_s    = s;
		next_s.q1 = din;
		next_s.q2 = s.q1;
		next_s.q3 = s.q2;
		if (s.q2 == s.q3) begin
			next_s.q = s.q3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= {INIT, INIT, INIT, INIT};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;

endmodule : isp_sync
